//--- design/sector_dma_regs.vh
// Purpose: Register map, field positions, reset values and timing counts
//          of the sector transfer request control block.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes:   Printed offsets are indices; the byte address is four times one.
`ifndef SECTOR_DMA_REGS_VH
`define SECTOR_DMA_REGS_VH

// ----------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------
`define IDX_XFER_CTRL       16'h1078
`define IDX_RELEASE_POINT   16'h107A
`define IDX_EVENT_STATUS    16'h1080
`define IDX_EVENT_MASK      16'h1081
`define ADDR_XFER_CTRL      16'h41E0
`define ADDR_RELEASE_POINT  16'h41E8
`define ADDR_EVENT_STATUS   16'h4200
`define ADDR_EVENT_MASK     16'h4204

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTRL_COUNT_MSB      6
`define CTRL_POLARITY_BIT   12
`define CTRL_EDGE_BIT       13
`define CTRL_PAUSE_BIT      14
`define CTRL_ENABLE_BIT     15
`define RELEASE_MSB         9
`define EVT_DONE_BIT        0
`define EVT_ECC_BIT         1
`define EVT_WIDTH           2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define XFER_CTRL_RESET     16'h0000
`define RELEASE_RESET       10'h000
`define EVT_MASK_RESET      2'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS       20
`define REQ_PULSE_NS        250
`define REQ_PULSE_CYCLES    \
    ((`REQ_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- design/request_pulse_timer.v
// Purpose: Holds a busy level for a fixed number of cycles after a start.
// Assumes: Start pulses are one cycle wide.
// Notes:   A start while busy restarts the count.
`timescale 1ns/1ps

module request_pulse_timer
#(
    parameter COUNT = 13,
    parameter WIDTH = 8
)
(
    // Clock and reset
    input  wire             sys_clk,
    input  wire             rst,
    // Control
    input  wire             start,
    input  wire             abort,
    // Status
    output reg              busy
);

    reg [WIDTH-1:0] count_reg;

    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            count_reg <= {WIDTH{1'b0}};
            busy      <= 1'b0;
        end
        else if (abort)
        begin
            count_reg <= {WIDTH{1'b0}};
            busy      <= 1'b0;
        end
        else if (start)
        begin
            count_reg <= COUNT[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1};
            busy      <= 1'b1;
        end
        else if (count_reg != {WIDTH{1'b0}})
        begin
            count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
        end
        else
        begin
            busy <= 1'b0;
        end
    end

endmodule // request_pulse_timer

//--- design/event_status.v
// Purpose: Sticky event flags with a masked level interrupt.
// Assumes: The clear mask is the value software just read.
// Notes:   A set in the clearing cycle wins, so no event is lost.
`timescale 1ns/1ps

module event_status
#(
    parameter WIDTH = 2
)
(
    // Clock and reset
    input  wire             sys_clk,
    input  wire             rst,
    // Events and software access
    input  wire [WIDTH-1:0] setPulse,
    input  wire [WIDTH-1:0] clearMask,
    input  wire [WIDTH-1:0] mask,
    // Results
    output reg  [WIDTH-1:0] status,
    output reg              irq
);

    wire [WIDTH-1:0] status_next;

    assign status_next = (status & ~clearMask) | setPulse;

    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            status <= {WIDTH{1'b0}};
            irq    <= 1'b0;
        end
        else
        begin
            status <= status_next;
            irq    <= |(status_next & mask);
        end
    end

endmodule // event_status

//--- design/sector_dma_request_control.v
// Purpose: Sector based transfer request control with an APB register file.
// Assumes: The ECC unit supplies its byte counter and sector/error pulses.
// Notes:   Summary of operation follows.
// Summary of operation
// RL1: Count field holds sectors to move minus one.
// RL2: Written zero moves exactly one sector.
// RL3: Read count equals remaining sectors minus one.
// RL4: Count decrements after each sector checksum read.
// RL5: On ECC error count shows sectors left minus one.
// RL6: Polarity clear: request idles high, asserts low.
// RL7: Polarity set: request idles low, asserts high.
// RL8: Edge style: request pulses about 250 ns.
// RL9: Level style: negate when counter hits release.
// RL10: ECC error during transfer sets pause bit.
// RL11: Software fixes data, then clears pause.
// RL12: Enable bit turns the transfer engine on.
// RL13: Software programs release as remaining+16+per-cycle.
// RL14: Unused control bits read back zero.
// RL15: While paused, no requests, progress held.
// RL16: ECC byte counter is an input.
`timescale 1ns/1ps
`include "sector_dma_regs.vh"

module sector_dma_request_control
#(
    parameter PULSE_CYCLES = `REQ_PULSE_CYCLES
)
(
    // Clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // APB slave
    input  wire [15:0] paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // ECC unit
    input  wire [9:0]  eccByteCounter,
    input  wire        busCycleStart,
    input  wire        sectorChecksumRead,
    input  wire        eccErrorDetected,
    // Host transfer request and interrupt
    output reg         transferRequestN,
    output wire        irq
);

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_ISSUE = 2'h1;
    localparam [1:0] ST_WAIT  = 2'h2;
    localparam [15:0] CTRL_RESET = `XFER_CTRL_RESET;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg  [6:0]  count_reg,     count_next;
    reg         polarity_reg,  polarity_next;
    reg         edge_reg,      edge_next;
    reg         pause_reg,     pause_next;
    reg         enable_reg,    enable_next;
    reg  [9:0]  release_reg,   release_next;
    reg  [1:0]  mask_reg,      mask_next;
    reg  [1:0]  state_reg,     state_next;
    reg         level_reg,     level_next;
    reg  [1:0]  readClear_reg, readClear_next;

    reg         pulseStart;
    reg         doneEvent;
    reg         eccEvent;
    reg  [31:0] readData;
    reg         addrHit;

    wire        setupPhase;
    wire        accessDone;
    wire        writeCtrl;
    wire        writeRelease;
    wire        writeMask;
    wire        pulseBusy;
    wire        requestActive;
    wire [1:0]  eventStatus;
    wire [15:0] ctrlReadValue;

    assign setupPhase = psel & ~penable;
    assign accessDone = psel & penable & pready;
    assign writeCtrl    = accessDone & pwrite &
                          (paddr == `ADDR_XFER_CTRL);
    assign writeRelease = accessDone & pwrite &
                          (paddr == `ADDR_RELEASE_POINT);
    assign writeMask    = accessDone & pwrite &
                          (paddr == `ADDR_EVENT_MASK);

    // Unused bits are padded with zeros on read.
    assign ctrlReadValue = {enable_reg, pause_reg, edge_reg, polarity_reg,
                            5'h00, count_reg}; // RL14

    // ------------------------------------------------------------------
    // APB read decode
    // ------------------------------------------------------------------
    always @*
    begin
        readData = 32'h00000000;
        addrHit  = 1'b1;
        case (paddr)
            `ADDR_XFER_CTRL:     readData = {16'h0000, ctrlReadValue}; // RL3
            `ADDR_RELEASE_POINT: readData = {22'h000000, release_reg}; // RL14
            `ADDR_EVENT_STATUS:  readData = {30'h00000000, eventStatus};
            `ADDR_EVENT_MASK:    readData = {30'h00000000, mask_reg};
            default:             addrHit  = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // APB handshake: one cycle from setup to a ready access phase
    // ------------------------------------------------------------------
    // Status bits captured at setup are the only ones cleared at the
    // access edge, so an event arriving in between stays pending.
    always @*
    begin
        readClear_next = readClear_reg;
        if (setupPhase)
            readClear_next = (!pwrite && paddr == `ADDR_EVENT_STATUS) ?
                             eventStatus : 2'h0;
    end

    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            prdata        <= 32'h00000000;
            pready        <= 1'b0;
            pslverr       <= 1'b0;
            readClear_reg <= 2'h0;
        end
        else
        begin
            readClear_reg <= readClear_next;
            if (setupPhase)
            begin
                pready  <= 1'b1;
                pslverr <= ~addrHit;
                prdata  <= pwrite ? 32'h00000000 : readData;
            end
            else
            begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control registers and sector sequencer
    // ------------------------------------------------------------------
    always @*
    begin
        count_next    = count_reg;
        polarity_next = polarity_reg;
        edge_next     = edge_reg;
        pause_next    = pause_reg;
        enable_next   = enable_reg;
        release_next  = release_reg;
        mask_next     = mask_reg;
        state_next    = state_reg;
        level_next    = level_reg;
        pulseStart    = 1'b0;
        doneEvent     = 1'b0;
        eccEvent      = 1'b0;

        if (writeCtrl)
        begin
            count_next    = pwdata[`CTRL_COUNT_MSB:0]; // RL1
            polarity_next = pwdata[`CTRL_POLARITY_BIT];
            edge_next     = pwdata[`CTRL_EDGE_BIT];
            pause_next    = pwdata[`CTRL_PAUSE_BIT]; // RL11
            enable_next   = pwdata[`CTRL_ENABLE_BIT]; // RL12
        end
        if (writeRelease)
        begin
            release_next = pwdata[`RELEASE_MSB:0]; // RL13
        end
        if (writeMask)
        begin
            mask_next = pwdata[`EVT_WIDTH-1:0];
        end

        case (state_reg)
            ST_IDLE:
            begin
                level_next = 1'b0;
                if (enable_reg)
                    state_next = ST_ISSUE; // RL12
            end
            ST_ISSUE:
            begin
                // A paused engine raises no new request.
                if (!enable_reg)
                    state_next = ST_IDLE;
                else if (!pause_reg) // RL15
                begin
                    if (edge_reg)
                        pulseStart = 1'b1; // RL8
                    else
                        level_next = 1'b1; // RL9
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (level_reg && busCycleStart &&
                    eccByteCounter == release_reg) // RL9 RL16
                begin
                    level_next = 1'b0;
                end
                if (!enable_reg)
                begin
                    level_next = 1'b0;
                    state_next = ST_IDLE;
                end
                else if (sectorChecksumRead && !pause_reg) // RL15
                begin
                    level_next = 1'b0;
                    if (count_reg == 7'h00) // RL2
                    begin
                        enable_next = 1'b0;
                        doneEvent   = 1'b1;
                        state_next  = ST_IDLE;
                    end
                    else
                    begin
                        count_next = count_reg - 7'h01; // RL4
                        state_next = ST_ISSUE;
                    end
                end
            end
            default:
            begin
                state_next = ST_IDLE;
                level_next = 1'b0;
            end
        endcase

        // The error leaves the count as it is, showing sectors left minus one.
        if (eccErrorDetected && enable_reg && state_reg != ST_IDLE)
        begin
            pause_next = 1'b1; // RL10 RL5
            eccEvent   = 1'b1;
        end
    end

    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            count_reg    <= CTRL_RESET[`CTRL_COUNT_MSB:0];
            polarity_reg <= CTRL_RESET[`CTRL_POLARITY_BIT];
            edge_reg     <= CTRL_RESET[`CTRL_EDGE_BIT];
            pause_reg    <= CTRL_RESET[`CTRL_PAUSE_BIT];
            enable_reg   <= CTRL_RESET[`CTRL_ENABLE_BIT];
            release_reg  <= `RELEASE_RESET;
            mask_reg     <= `EVT_MASK_RESET;
            state_reg    <= ST_IDLE;
            level_reg    <= 1'b0;
        end
        else
        begin
            count_reg    <= count_next;
            polarity_reg <= polarity_next;
            edge_reg     <= edge_next;
            pause_reg    <= pause_next;
            enable_reg   <= enable_next;
            release_reg  <= release_next;
            mask_reg     <= mask_next;
            state_reg    <= state_next;
            level_reg    <= level_next;
        end
    end

    // ------------------------------------------------------------------
    // Request pulse timer
    // ------------------------------------------------------------------
    request_pulse_timer
    #(
        .COUNT (PULSE_CYCLES),
        .WIDTH (8)
    )
    u_pulse
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .start   (pulseStart),
        .abort   (~enable_reg),
        .busy    (pulseBusy)
    );

    // Pause drops a live request so the host stops pulling data.
    // A disabling write drops a live request at once as well.
    assign requestActive = (pulseBusy | level_reg) & ~pause_reg &
                           enable_reg; // RL15

    // ------------------------------------------------------------------
    // Request output
    // ------------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            transferRequestN <= 1'b1;
        end
        else if (polarity_reg)
        begin
            transferRequestN <= requestActive; // RL7
        end
        else
        begin
            transferRequestN <= ~requestActive; // RL6
        end
    end

    // ------------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------------
    event_status
    #(
        .WIDTH (`EVT_WIDTH)
    )
    u_events
    (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .setPulse  ({eccEvent, doneEvent}),
        .clearMask (accessDone ? readClear_reg : 2'h0),
        .mask      (mask_reg),
        .status    (eventStatus),
        .irq       (irq)
    );

endmodule // sector_dma_request_control

//--- tb/sector_dma_asserts.sv
// Purpose: Port level checks for the sector transfer request control block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Polarity, style and release point are shadowed from APB writes.
`timescale 1ns/1ps
`include "sector_dma_regs.vh"

module sector_dma_asserts
#(
    parameter PULSE_CYCLES = 13
)
(
    // Clock and reset
    input wire        sys_clk,
    input wire        rst,
    // APB
    input wire [15:0] paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // ECC unit and host
    input wire [9:0]  eccByteCounter,
    input wire        busCycleStart,
    input wire        sectorChecksumRead,
    input wire        eccErrorDetected,
    input wire        transferRequestN,
    input wire        irq
);
    reg       polReg;
    reg       edgeReg;
    reg [9:0] relReg;
    reg [7:0] pulseCnt;
    wire      wrDone = psel && penable && pready && pwrite;
    wire      rdOk = pready && !pwrite;
    wire      reqOn = (transferRequestN == polReg);
    wire      isCtrl = (paddr == `ADDR_XFER_CTRL);
    wire      isRel = (paddr == `ADDR_RELEASE_POINT);
    wire      mapped = isCtrl || isRel || (paddr == `ADDR_EVENT_STATUS)
                       || (paddr == `ADDR_EVENT_MASK);

    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            polReg <= 1'b0;
            edgeReg <= 1'b0;
            relReg <= 10'h000;
            pulseCnt <= 8'h00;
        end
        else
        begin
            if (wrDone && isCtrl)
            begin
                polReg <= pwdata[12];
                edgeReg <= pwdata[13];
            end
            if (wrDone && isRel)
                relReg <= pwdata[9:0];
            pulseCnt <= reqOn ? pulseCnt + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_pready_next: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_pready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_unmapped_err: assert property (psel && !penable && !mapped
        |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_ctrl_reserved: assert property (rdOk && isCtrl
        |-> prdata[11:7] == 5'h00 && prdata[31:16] == 16'h0000)
        else $error("control reserved bits not zero");
    a_release_reserved: assert property (rdOk && isRel
        |-> prdata[31:10] == 22'h000000)
        else $error("release reserved bits not zero");
    a_idle_polarity: assert property (wrDone && isCtrl && !pwdata[15]
        |-> ##2 transferRequestN != $past(pwdata[12], 2))
        else $error("idle request level wrong");
    a_pulse_width: assert property ($fell(reqOn) && edgeReg
        && $past(polReg, 4) == polReg |-> pulseCnt == PULSE_CYCLES)
        else $error("request pulse width wrong");
    a_level_release: assert property (!edgeReg && reqOn && busCycleStart
        && eccByteCounter == relReg |-> ##[1:2] !reqOn)
        else $error("level request not released");
    a_pause_holds: assert property (eccErrorDetected && reqOn && !edgeReg
        |-> ##2 !reqOn [*6])
        else $error("request not withdrawn on pause");

    c_pulse: cover property ($fell(reqOn) && edgeReg);
    c_release: cover property (busCycleStart && reqOn
        && eccByteCounter == relReg);
    c_error: cover property (eccErrorDetected && reqOn);
endmodule // sector_dma_asserts

bind sector_dma_request_control sector_dma_asserts
    #(.PULSE_CYCLES(PULSE_CYCLES)) chk (.sys_clk(sys_clk), .rst(rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eccByteCounter(eccByteCounter), .busCycleStart(busCycleStart),
    .sectorChecksumRead(sectorChecksumRead),
    .eccErrorDetected(eccErrorDetected),
    .transferRequestN(transferRequestN), .irq(irq));

//--- tb/host_dma_model.sv
// Purpose: Host transfer controller and ECC unit seen from the request pin.
// Assumes: One bus cycle moves two bytes; a sector ends at count zero.
// Notes:   A sector starts only on a fresh request, so each resume after a pause re-arms.
`timescale 1ns/1ps

module host_dma_model
(
    // Clock and reset
    input  wire       sys_clk,
    input  wire       rst,
    // Request and test controls
    input  wire       transferRequestN,
    input  wire       pol,
    input  wire       slow,
    input  wire       injErr,
    input  wire       listen,
    // ECC unit side
    output reg  [9:0] eccByteCounter,
    output reg        busCycleStart,
    output reg        sectorChecksumRead,
    output reg        eccErrorDetected,
    output int        sectorsDone
);
    reg       active;
    reg       prevOn;
    reg       errSent;
    reg [3:0] gap;
    wire      reqOn = listen && (transferRequestN == pol);

    always @(posedge sys_clk)
    begin
        busCycleStart <= 1'b0;
        sectorChecksumRead <= 1'b0;
        eccErrorDetected <= 1'b0;
        prevOn <= reqOn;
        if (rst)
        begin
            active <= 1'b0;
            errSent <= 1'b0;
            eccByteCounter <= 10'h000;
            sectorsDone <= 0;
        end
        else if (!active)
        begin
            if (reqOn && !prevOn)
            begin
                active <= 1'b1;
                gap <= slow ? 4'h6 : 4'h0;
                eccByteCounter <= 10'h028;
            end
        end
        else if (gap != 4'h0)
            gap <= gap - 4'h1;
        else if (injErr && !errSent && eccByteCounter == 10'h01E)
        begin
            eccErrorDetected <= 1'b1;
            errSent <= 1'b1;
            active <= 1'b0;
        end
        else if (eccByteCounter == 10'h000)
        begin
            sectorChecksumRead <= 1'b1;
            sectorsDone <= sectorsDone + 1;
            active <= 1'b0;
        end
        else
        begin
            busCycleStart <= 1'b1;
            eccByteCounter <= eccByteCounter - 10'h002;
        end
    end
endmodule // host_dma_model

//--- tb/sector_dma_request_control_tb.sv
// Purpose: Register and transfer checks of the sector request control block.
// Assumes: Zero wait APB slave; short request pulse of three cycles.
// Notes:   Expected values follow from the register layout and the sector sequence.
`timescale 1ns/1ps
`include "sector_dma_regs.vh"

module sector_dma_request_control_tb;
    localparam [15:0] CTRL = `ADDR_XFER_CTRL;
    localparam [15:0] REL = `ADDR_RELEASE_POINT;
    localparam [15:0] STAT = `ADDR_EVENT_STATUS;
    localparam [15:0] MASK = `ADDR_EVENT_MASK;
    reg        sys_clk;
    reg        rst;
    reg        psel;
    reg        penable;
    reg        pwrite;
    reg [15:0] paddr;
    reg [31:0] pwdata;
    reg        pol;
    reg        slow;
    reg        injErr;
    reg        listen;
    reg [31:0] rd;
    reg        err;
    wire [31:0] prdata;
    wire       pready;
    wire       pslverr;
    wire [9:0] eccByteCounter;
    wire       busCycleStart;
    wire       sectorChecksumRead;
    wire       eccErrorDetected;
    wire       transferRequestN;
    wire       irq;
    int        sectorsDone;
    int        failCount;
    int        checks;

    sector_dma_request_control #(.PULSE_CYCLES(3)) dut (.sys_clk(sys_clk),
        .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .eccByteCounter(eccByteCounter),
        .busCycleStart(busCycleStart), .sectorChecksumRead(sectorChecksumRead),
        .eccErrorDetected(eccErrorDetected),
        .transferRequestN(transferRequestN), .irq(irq));

    host_dma_model host (.sys_clk(sys_clk), .rst(rst),
        .transferRequestN(transferRequestN), .pol(pol), .slow(slow),
        .injErr(injErr), .listen(listen), .eccByteCounter(eccByteCounter),
        .busCycleStart(busCycleStart), .sectorChecksumRead(sectorChecksumRead),
        .eccErrorDetected(eccErrorDetected), .sectorsDone(sectorsDone));

    task wrapUp;
        if (failCount == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task check(input string what, input [31:0] exp, input [31:0] got);
        checks++;
        if (got !== exp)
        begin
            failCount++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; entered and left just after a rising edge.
    task apb(input [15:0] a, input w, input [31:0] d);
        int n;
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        @(posedge sys_clk);
        // Read before this edge's updates land, so pready is as sampled.
        while (pready !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge sys_clk);
        end
        check("pready wait", 32'h0, (n == 50) ? 32'h1 : 32'h0);
        if (n == 50)
            wrapUp;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task rdChk(input [15:0] a, input [31:0] exp);
        apb(a, 1'b0, 32'h0);
        check($sformatf("read %h", a), exp, rd);
    endtask

    // A negative count waits for the interrupt instead of sectors.
    task waitFor(input int n);
        int k;
        k = 0;
        while ((n < 0 ? irq !== 1'b1 : sectorsDone < n) && k < 3000)
        begin
            k++;
            @(negedge sys_clk);
        end
        @(posedge sys_clk);
        if (k == 3000)
        begin
            failCount++;
            wrapUp;
        end
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    initial
    begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 48'h0};
        {pol, slow, injErr, listen} = 4'h0;
        failCount = 0;
        checks = 0;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        rdChk(CTRL, 32'h0);
        rdChk(REL, 32'h0);
        rdChk(STAT, 32'h0);
        rdChk(MASK, 32'h0);
        apb(16'h41E4, 1'b0, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        apb(CTRL, 1'b1, 32'h3FFF);
        rdChk(CTRL, 32'h307F);
        check("request idle", 32'h0, {31'h0, transferRequestN});
        apb(REL, 1'b1, 32'hFFFF);
        rdChk(REL, 32'h3FF);
        pol <= 1'b1;
        slow <= 1'b1;
        listen <= 1'b1;
        apb(CTRL, 1'b1, 32'hB000);
        waitFor(1);
        repeat (60) @(posedge sys_clk);
        check("sectors", 32'h1, sectorsDone);
        check("masked irq", 32'h0, {31'h0, irq});
        rdChk(STAT, 32'h1);
        rdChk(CTRL, 32'h3000);
        listen <= 1'b0;
        apb(CTRL, 1'b1, 32'h0);
        apb(REL, 1'b1, 32'h14);
        check("request idle", 32'h1, {31'h0, transferRequestN});
        apb(MASK, 1'b1, 32'h1);
        pol <= 1'b0;
        slow <= 1'b0;
        listen <= 1'b1;
        apb(CTRL, 1'b1, 32'h8002);
        waitFor(2);
        rdChk(CTRL, 32'h8001);
        waitFor(4);
        waitFor(-1);
        rdChk(STAT, 32'h1);
        repeat (2) @(posedge sys_clk);
        check("irq after read", 32'h0, {31'h0, irq});
        rdChk(CTRL, 32'h0);
        apb(MASK, 1'b1, 32'h2);
        injErr <= 1'b1;
        apb(CTRL, 1'b1, 32'h8001);
        waitFor(-1);
        repeat (10) @(posedge sys_clk);
        check("held progress", 32'h4, sectorsDone);
        rdChk(CTRL, 32'hC001);
        rdChk(STAT, 32'h2);
        injErr <= 1'b0;
        apb(CTRL, 1'b1, 32'h8001);
        waitFor(6);
        repeat (4) @(posedge sys_clk);
        rdChk(CTRL, 32'h0);
        rdChk(STAT, 32'h1);
        wrapUp;
    end
endmodule // sector_dma_request_control_tb
